/* rtl/or_literal_and_skip_exec.sv */
// Executes the OR-literal instruction and the discard cycles after a taken skip.
// Assumes the fetch unit presents one opcode per instruction cycle on opcode_i.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The OR-literal instruction ORs an eight-bit literal (0 to 255) into the accumulator.
// - The result replaces the accumulator and no file register is written.
// - Only the negative and zero flags are updated from the result.
// - The instruction is recognised by upper opcode byte 0000 1001, low byte the literal.
module or_literal_and_skip_exec #(
  parameter int DATA_W = or_skip_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Fetch pipeline
  input  wire logic [15:0]       opcode_i,
  input  wire logic              opcode_valid_i,
  // Skip request from the increment-skip datapath
  input  wire logic              skip_taken_i,
  // Flags from the rest of the core
  input  wire logic [4:0]        status_i,
  // Results
  output logic [DATA_W-1:0]      accum_o,
  output logic [4:0]             status_o,
  output logic                   status_we_o,
  output logic                   file_we_o,
  output logic                   discard_o,
  output logic [1:0]             q_phase_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DROP1 = 3'b010,
    ST_DROP2 = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t             mode;
    logic [1:0]        q;
    logic [DATA_W-1:0] accum;
    logic [4:0]        status;
    logic              status_we;
    logic              discard;
    logic              skip_pend;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic is_or_literal(input logic [15:0] op);
    is_or_literal = (op[15:8] == or_skip_pkg::ORLIT_OPC_HI);
  endfunction

  function automatic logic is_two_word(input logic [15:0] op);
    is_two_word = (op[15:12] == or_skip_pkg::TWO_WORD_HI_A) ||
                  (op[15:12] == or_skip_pkg::TWO_WORD_HI_B);
  endfunction

  logic [DATA_W-1:0] or_result;
  assign or_result = s_q.accum | opcode_i[DATA_W-1:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.status_we = 1'b0;
    s_d.q         = s_q.q + 2'h1;
    // Skip may arrive mid-cycle; held until the cycle boundary
    if (skip_taken_i) begin
      s_d.skip_pend = 1'b1;
    end
    if (s_q.q == or_skip_pkg::Q_LAST) begin
      s_d.discard   = 1'b0;
      case (s_q.mode)
        ST_RUN: begin
          if (s_q.skip_pend || skip_taken_i) begin
            s_d.skip_pend = 1'b0;
            s_d.discard   = 1'b1;
            // Two-word follower costs one extra dead cycle
            s_d.mode      = (opcode_valid_i && is_two_word(opcode_i)) ? ST_DROP2 : ST_DROP1;
          end else if (opcode_valid_i && is_or_literal(opcode_i)) begin
            s_d.accum     = or_result;
            s_d.status    = status_i;
            s_d.status[4] = or_result[DATA_W-1];
            s_d.status[2] = (or_result == '0);
            s_d.status_we = 1'b1;
          end
        end
        ST_DROP1: begin
          s_d.mode = ST_RUN;
        end
        ST_DROP2: begin
          s_d.discard = 1'b1;
          s_d.mode    = ST_DROP1;
        end
        default: begin
          s_d.mode = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.mode      <= ST_RUN;
      s_q.q         <= or_skip_pkg::Q_RESET;
      s_q.accum     <= or_skip_pkg::W_RESET;
      s_q.status    <= 5'h00;
      s_q.status_we <= 1'b0;
      s_q.discard   <= 1'b0;
      s_q.skip_pend <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign accum_o     = s_q.accum;
  assign status_o    = s_q.status;
  assign status_we_o = s_q.status_we;
  // Never writes data memory
  assign file_we_o   = 1'b0;
  assign discard_o   = s_q.discard;
  assign q_phase_o   = s_q.q;
endmodule
`default_nettype wire

/* rtl/or_skip_pkg.sv */
// Constants for the OR-literal executor and skip-cycle handling.
// Assumes a single 20 MHz system clock; no software-visible registers.
package or_skip_pkg;
  // ****************************************************************
  // Encoding
  // ****************************************************************
  localparam logic [7:0] ORLIT_OPC_HI  = 8'h09;
  localparam int         OPC_W         = 16;
  localparam int         DATA_W        = 8;
  // Upper nibble of a second instruction word
  localparam logic [3:0] SECOND_WORD_HI = 4'hF;
  // Two-word first words: upper nibble 1100 and 1110 (call/goto/lfsr family)
  localparam logic [3:0] TWO_WORD_HI_A  = 4'hC;
  localparam logic [3:0] TWO_WORD_HI_B  = 4'hE;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLK_HZ        = 20_000_000;
  localparam int         Q_PHASES      = 4;
  localparam logic [1:0] Q_LAST        = 2'h3;
  localparam logic [1:0] Q_RESET       = 2'h0;
  localparam logic [7:0] W_RESET       = 8'h00;
endpackage

/* sim/or_skip_monitor.sv */
// Port checker for the OR-literal executor.
// Assumes the bench pulses skip only at the last phase.
`timescale 1ns/1ps
`default_nettype none
module or_skip_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [15:0] opcode_i,
  input wire logic        opcode_valid_i,
  input wire logic        skip_taken_i,
  input wire logic [4:0]  status_i,
  input wire logic [7:0]  accum_o,
  input wire logic [4:0]  status_o,
  input wire logic        status_we_o,
  input wire logic        file_we_o,
  input wire logic        discard_o,
  input wire logic [1:0]  q_phase_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_or_result:
    assert property (status_we_o |-> accum_o == ($past(accum_o) | $past(opcode_i[7:0])))
    else $error("accumulator not the OR of literal");
  a_we_cause:
    assert property (status_we_o |-> $past(q_phase_o) == 2'h3 && $past(opcode_valid_i)
      && $past(opcode_i[15:8]) == 8'h09) else $error("flag write without OR opcode");
  a_flag_update:
    assert property (status_we_o |-> status_o[4] == accum_o[7] && status_o[2] == (accum_o == 8'h00)
      && status_o[3] == $past(status_i[3]) && status_o[1:0] == $past(status_i[1:0]))
    else $error("flags wrong after OR");
  a_no_file:
    assert property (file_we_o == 1'b0) else $error("file register written");
  a_skip_discard:
    assert property (q_phase_o == 2'h3 && skip_taken_i |=> discard_o [*4])
    else $error("skip not followed by discard cycle");
endmodule
bind or_literal_and_skip_exec or_skip_monitor mon (.*);
`default_nettype wire

/* sim/or_literal_and_skip_exec_tb.sv */
// Bench for the OR-literal executor.
// Drives every input except the clock at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module or_literal_and_skip_exec_tb;
  logic        clk_sys_i = 0, rst_i = 1, opcode_valid_i = 0, skip_taken_i = 0;
  logic [15:0] opcode_i = 16'h0000;
  logic [4:0]  status_i = 5'h0B, status_o;
  logic [7:0]  accum_o;
  logic        status_we_o, file_we_o, discard_o;
  logic [1:0]  q_phase_o;
  int          mismatches = 0, samples_checked = 0, n;
  // Literal, accumulator, flags; runs from a cleared accumulator
  logic [23:0] rows [4] = '{24'h00000F, 24'h9A9A1B, 24'h35BF1B, 24'hFFFF1B};
  or_literal_and_skip_exec uut (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .opcode_i       (opcode_i),
    .opcode_valid_i (opcode_valid_i),
    .skip_taken_i   (skip_taken_i),
    .status_i       (status_i),
    .accum_o        (accum_o),
    .status_o       (status_o),
    .status_we_o    (status_we_o),
    .file_we_o      (file_we_o),
    .discard_o      (discard_o),
    .q_phase_o      (q_phase_o)
  );
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic issue(logic [15:0] op, logic sk);
    do @(negedge clk_sys_i); while (q_phase_o !== 2'h3);
    opcode_i = op;
    opcode_valid_i = 1;
    skip_taken_i = sk;
    @(negedge clk_sys_i);
    opcode_valid_i = 0;
    skip_taken_i = 0;
  endtask
  task automatic finish_test;
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 0;
    foreach (rows[i]) begin
      issue({8'h09, rows[i][23:16]}, 0);
      chk("accum", rows[i][15:8], accum_o);
      chk("status", {3'h0, rows[i][4:0]}, {3'h0, status_o});
      chk("status_we", 1, status_we_o);
      chk("file_we", 0, {7'h00, file_we_o});
    end
    $display("table done");
    issue(16'h0AFF, 0);
    chk("status_we", 0, status_we_o);
    rst_i = 1;
    @(negedge clk_sys_i);
    chk("accum", 0, accum_o);
    rst_i = 0;
    $display("reset done");
    // Second word of a two-word follower must also be dropped
    for (int k = 0; k < 2; k++) begin
      issue(k ? 16'hC000 : 16'h0943, 1);
      n = 0;
      repeat (12) begin
        n += discard_o;
        @(negedge clk_sys_i);
      end
      chk("discard cycles", k ? 8 : 4, n[7:0]);
      chk("accum", 0, accum_o);
    end
    $display("skip done");
    // Negative and zero flags must follow the result, not status_i
    status_i = 5'h14;
    issue(16'h0901, 0);
    chk("accum", 8'h01, accum_o);
    chk("status", 8'h00, {3'h0, status_o});
    $display("flag copy done");
    finish_test;
  end
endmodule
`default_nettype wire
